// File: sssx_pkg.sv
// Purpose: constants for the store, subtract and swap execution block
// Assumes: 16-bit instruction words, 32-bit data, AXI4-Lite register access
// Notes: offsets are byte addresses on the register bus
//
// Functional notes
// - plain static byte store writes base plus two-bit immediate, lane from immediate
// - prefixed static byte store adds sign-extended 13-bit prefix:immediate to base
// - prefixed static byte store still picks source byte by two-bit immediate
// - plain pointer word store uses aligned base plus immediate times four
// - pointer word store base is one of four locals, index minus 16
// - prefixed pointer store adds sign-extended 16-bit offset times four
// - stack word store writes to aligned stack pointer plus eight-bit immediate times four
// - stack half store uses stack pointer plus twice immediate, instruction bit one picks half
// - stack byte store uses stack pointer plus immediate, low bits pick byte
// - stack half store decoded by upper opcode bits and bit zero clear
// - register subtract writes difference and sets all four flags
// - plain immediate subtract takes unsigned five-bit immediate, sets flags
// - prefixed immediate subtract uses zero-extended prefix:immediate
// - half swap exchanges register halves, flags untouched
// - stores never touch the condition flags
// - static byte store decoded by bits 15..10 and bits 9..7 equal to 100
`default_nettype none
package sssx_pkg;
   // ***************************
   // register map
   // ***************************
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_OPA = 8'h04;
   localparam logic [7:0] ADDR_OPB = 8'h08;
   localparam logic [7:0] ADDR_SP = 8'h0c;
   localparam logic [7:0] ADDR_R0 = 8'h10;
   localparam logic [7:0] ADDR_LOCAL = 8'h14;
   localparam logic [7:0] ADDR_RESULT = 8'h18;
   localparam logic [7:0] ADDR_FLAGS = 8'h1c;
   localparam logic [7:0] ADDR_MADDR = 8'h20;
   localparam logic [7:0] ADDR_MDATA = 8'h24;
   localparam logic [7:0] ADDR_STATUS = 8'h28;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ***************************
   // opcode fields
   // ***************************
   localparam logic [5:0] OP_STATIC_BYTE = 6'h1d; // bits 15..10 = 011101, bits 9..7 = 100
   localparam logic [2:0] OP_STATIC_BYTE_LO = 3'h4;
   localparam logic [3:0] OP_POINTER = 4'ha;
   localparam logic [2:0] OP_STACK_WORD = 3'h6;
   localparam logic [5:0] OP_STACK_HALF = 6'h19;
   localparam logic [5:0] OP_STACK_BYTE = 6'h18;
   localparam logic [5:0] OP_SUB_REG = 6'h02;
   localparam logic [5:0] OP_SUB_IMM = 6'h03;
   localparam logic [10:0] OP_SWAP = 11'h3e8;
   localparam logic [4:0] OP_PREFIX = 5'h13;
   localparam int FLAG_N = 3;
   localparam int FLAG_V = 2;
   localparam int FLAG_Z = 1;
   localparam int FLAG_C = 0;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   typedef enum logic [2:0] {
      SSSX_IDLE = 3'b001,
      SSSX_EXEC = 3'b010,
      SSSX_DONE = 3'b100
   } sssx_state_t;
endpackage
`default_nettype wire

// File: sssx_exec_unit.sv
// Purpose: combinational decode and execute of one instruction
// Assumes: operands supplied by the caller
// Notes: no state
`default_nettype none
module sssx_exec_unit (
   // instruction
   input wire logic [15:0] instr_in,
   input wire logic pfx_valid_in,
   input wire logic [10:0] pfx_value_in,
   // operands
   input wire logic [31:0] opa_in,
   input wire logic [31:0] opb_in,
   input wire logic [31:0] sp_in,
   input wire logic [31:0] r0_in,
   input wire logic [31:0] local_in,
   input wire logic [3:0] flags_in,
   // results
   output logic is_prefix_out,
   output logic known_out,
   output logic store_out,
   output logic [31:0] maddr_out,
   output logic [31:0] mdata_out,
   output logic [3:0] mstrb_out,
   output logic reg_wr_out,
   output logic [31:0] result_out,
   output logic [3:0] flags_out,
   output logic [1:0] local_sel_out
);
   logic [31:0] sub_b;
   logic [32:0] diff;
   logic [31:0] word_base;
   logic [31:0] byte_addr;
   logic [1:0] lane;
   always_comb begin
      is_prefix_out = is_prefix_out_f(instr_in);
      known_out = 1'b1;
      store_out = 1'b0;
      reg_wr_out = 1'b0;
      maddr_out = 32'h0;
      mdata_out = 32'h0;
      mstrb_out = 4'h0;
      result_out = 32'h0;
      flags_out = flags_in;
      local_sel_out = instr_in[11:10];
      sub_b = opb_in;
      diff = 33'h0;
      word_base = 32'h0;
      byte_addr = 32'h0;
      lane = 2'h0;
      if (instr_in[15:12] == sssx_pkg::OP_POINTER) begin
         word_base = {local_in[31:2], 2'h0};
         if (pfx_valid_in) begin
            word_base = word_base + {{14{pfx_value_in[10]}}, pfx_value_in, instr_in[9:5], 2'h0};
         end else begin
            word_base = word_base + {25'h0, instr_in[9:5], 2'h0};
         end
         store_out = 1'b1;
         maddr_out = word_base;
         mdata_out = opa_in;
         mstrb_out = 4'hf;
      end else if (instr_in[15:13] == sssx_pkg::OP_STACK_WORD) begin
         store_out = 1'b1;
         maddr_out = {sp_in[31:2], 2'h0} + {22'h0, instr_in[12:5], 2'h0};
         mdata_out = opa_in;
         mstrb_out = 4'hf;
      end else if (instr_in[15:10] == sssx_pkg::OP_STACK_HALF && !instr_in[0]) begin
         byte_addr = sp_in + {22'h0, instr_in[9:1], 1'b0};
         store_out = 1'b1;
         maddr_out = {byte_addr[31:2], 2'h0};
         mdata_out = {r0_in[instr_in[1]*16 +: 16], r0_in[instr_in[1]*16 +: 16]};
         mstrb_out = instr_in[1] ? 4'hc : 4'h3;
      end else if (instr_in[15:10] == sssx_pkg::OP_STACK_BYTE) begin
         byte_addr = sp_in + {22'h0, instr_in[9:0]};
         lane = instr_in[1:0];
         store_out = 1'b1;
         maddr_out = {byte_addr[31:2], 2'h0};
         mdata_out = {4{r0_in[lane*8 +: 8]}};
         mstrb_out = 4'h1 << lane;
      end else if (instr_in[15:10] == sssx_pkg::OP_STATIC_BYTE
                   && instr_in[9:7] == sssx_pkg::OP_STATIC_BYTE_LO) begin
         lane = instr_in[6:5];
         if (pfx_valid_in) begin
            byte_addr = opa_in + {{19{pfx_value_in[10]}}, pfx_value_in, lane};
         end else begin
            byte_addr = opa_in + {30'h0, lane};
         end
         store_out = 1'b1;
         maddr_out = {byte_addr[31:2], 2'h0};
         mdata_out = {4{r0_in[lane*8 +: 8]}};
         mstrb_out = 4'h1 << byte_addr[1:0];
      end else if (instr_in[15:10] == sssx_pkg::OP_SUB_REG
                   || instr_in[15:10] == sssx_pkg::OP_SUB_IMM) begin
         if (instr_in[10]) begin
            sub_b = pfx_valid_in ? {16'h0, pfx_value_in, instr_in[9:5]}
                                 : {27'h0, instr_in[9:5]};
         end
         diff = {1'b0, opa_in} - {1'b0, sub_b};
         result_out = diff[31:0];
         reg_wr_out = 1'b1;
         flags_out[sssx_pkg::FLAG_N] = diff[31];
         flags_out[sssx_pkg::FLAG_V] = (opa_in[31] != sub_b[31]) && (diff[31] != opa_in[31]);
         flags_out[sssx_pkg::FLAG_Z] = diff[31:0] == 32'h0;
         flags_out[sssx_pkg::FLAG_C] = diff[32];
      end else if (instr_in[15:5] == sssx_pkg::OP_SWAP) begin
         result_out = {opa_in[15:0], opa_in[31:16]};
         reg_wr_out = 1'b1;
      end else if (!is_prefix_out_f(instr_in)) begin
         known_out = 1'b0;
      end
   end
   function automatic logic is_prefix_out_f(input logic [15:0] w);
      return w[15:11] == sssx_pkg::OP_PREFIX;
   endfunction
endmodule
`default_nettype wire

// File: sssx_top.sv
// Purpose: AXI4-Lite wrapper executing one instruction per write to the instruction register
// Assumes: software loads operands first, then writes an instruction word
// Notes: results and the memory write appear in readable registers
`default_nettype none
module sssx_top (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // write address
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   // write data
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   // write response
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // read address
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   // read data
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   // data memory write
   output logic mem_wr_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic [3:0] mem_be_out
);
   // ***************************
   // state
   // ***************************
   logic [31:0] opa_q, opb_q, sp_q, r0_q, result_q, maddr_q, mdata_q;
   logic [31:0] local_q [4];
   logic [3:0] flags_q, mstrb_q;
   logic pfx_valid_q, bad_q;
   logic [10:0] pfx_value_q;
   logic [15:0] instr_q;
   sssx_pkg::sssx_state_t state_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic aw_have_q, w_have_q;
   logic is_pfx, known, store, reg_wr;
   logic [31:0] ex_maddr, ex_mdata, ex_result;
   logic [3:0] ex_strb, ex_flags;
   logic [1:0] local_sel;
   logic do_write;
   assign do_write = aw_have_q && w_have_q && !s_axi_bvalid_out
                     && state_q == sssx_pkg::SSSX_IDLE;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = st[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   sssx_exec_unit u_exec (
      .instr_in(instr_q),
      .pfx_valid_in(pfx_valid_q),
      .pfx_value_in(pfx_value_q),
      .opa_in(opa_q),
      .opb_in(opb_q),
      .sp_in(sp_q),
      .r0_in(r0_q),
      .local_in(local_q[local_sel]),
      .flags_in(flags_q),
      .is_prefix_out(is_pfx),
      .known_out(known),
      .store_out(store),
      .maddr_out(ex_maddr),
      .mdata_out(ex_mdata),
      .mstrb_out(ex_strb),
      .reg_wr_out(reg_wr),
      .result_out(ex_result),
      .flags_out(ex_flags),
      .local_sel_out(local_sel)
   );

   // ***************************
   // write channels
   // ***************************
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= 8'h0;
         wdata_q <= 32'h0;
         wstrb_q <= 4'h0;
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= sssx_pkg::RESP_OKAY;
      end else begin
         s_axi_awready_out <= !aw_have_q && !(s_axi_awvalid_in && s_axi_awready_out);
         s_axi_wready_out <= !w_have_q && !(s_axi_wvalid_in && s_axi_wready_out);
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr_in;
         end
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata_in;
            wstrb_q <= s_axi_wstrb_in;
         end
         if (do_write) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (awaddr_q[1:0] != 2'h0 || awaddr_q > sssx_pkg::ADDR_LOCAL + 8'h0c
                                || (awaddr_q >= sssx_pkg::ADDR_RESULT
                                    && awaddr_q < sssx_pkg::ADDR_LOCAL))
                               ? sssx_pkg::RESP_SLVERR : sssx_pkg::RESP_OKAY;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
      end
   end

   // ***************************
   // operand registers
   // ***************************
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         opa_q <= 32'h0;
         opb_q <= 32'h0;
         sp_q <= 32'h0;
         r0_q <= 32'h0;
         instr_q <= 16'h0;
         for (int i = 0; i < 4; i++) begin
            local_q[i] <= 32'h0;
         end
      end else if (do_write) begin
         unique case (awaddr_q)
            sssx_pkg::ADDR_INSTR: instr_q <= 16'(merge({16'h0, instr_q}, wdata_q, wstrb_q));
            sssx_pkg::ADDR_OPA: opa_q <= merge(opa_q, wdata_q, wstrb_q);
            sssx_pkg::ADDR_OPB: opb_q <= merge(opb_q, wdata_q, wstrb_q);
            sssx_pkg::ADDR_SP: sp_q <= merge(sp_q, wdata_q, wstrb_q);
            sssx_pkg::ADDR_R0: r0_q <= merge(r0_q, wdata_q, wstrb_q);
            sssx_pkg::ADDR_LOCAL: local_q[0] <= merge(local_q[0], wdata_q, wstrb_q);
            sssx_pkg::ADDR_RESULT: local_q[1] <= merge(local_q[1], wdata_q, wstrb_q);
            sssx_pkg::ADDR_FLAGS: local_q[2] <= merge(local_q[2], wdata_q, wstrb_q);
            sssx_pkg::ADDR_MADDR: local_q[3] <= merge(local_q[3], wdata_q, wstrb_q);
            default: ;
         endcase
      end else if (state_q == sssx_pkg::SSSX_EXEC && reg_wr) begin
         opa_q <= ex_result;
      end
   end

   // ***************************
   // execute sequence
   // ***************************
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= sssx_pkg::SSSX_IDLE;
         pfx_valid_q <= 1'b0;
         pfx_value_q <= 11'h0;
         flags_q <= sssx_pkg::FLAGS_RST;
         result_q <= 32'h0;
         maddr_q <= 32'h0;
         mdata_q <= 32'h0;
         mstrb_q <= 4'h0;
         bad_q <= 1'b0;
         mem_wr_out <= 1'b0;
         mem_addr_out <= 32'h0;
         mem_wdata_out <= 32'h0;
         mem_be_out <= 4'h0;
      end else begin
         mem_wr_out <= 1'b0;
         unique case (state_q)
            sssx_pkg::SSSX_IDLE: begin
               if (do_write && awaddr_q == sssx_pkg::ADDR_INSTR) begin
                  state_q <= sssx_pkg::SSSX_EXEC;
               end
            end
            sssx_pkg::SSSX_EXEC: begin
               state_q <= sssx_pkg::SSSX_DONE;
               flags_q <= ex_flags;
               bad_q <= !known;
               if (reg_wr) begin
                  result_q <= ex_result;
               end
               if (is_pfx) begin
                  pfx_valid_q <= 1'b1;
                  pfx_value_q <= instr_q[10:0];
               end else begin
                  pfx_valid_q <= 1'b0;
               end
               if (store) begin
                  maddr_q <= ex_maddr;
                  mdata_q <= ex_mdata;
                  mstrb_q <= ex_strb;
                  mem_wr_out <= 1'b1;
                  mem_addr_out <= ex_maddr;
                  mem_wdata_out <= ex_mdata;
                  mem_be_out <= ex_strb;
               end
            end
            sssx_pkg::SSSX_DONE: state_q <= sssx_pkg::SSSX_IDLE;
         endcase
      end
   end

   // ***************************
   // read channel
   // ***************************
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= 32'h0;
         s_axi_rresp_out <= sssx_pkg::RESP_OKAY;
      end else begin
         s_axi_arready_out <= !s_axi_rvalid_out && !(s_axi_arvalid_in && s_axi_arready_out);
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= sssx_pkg::RESP_OKAY;
            unique case (s_axi_araddr_in)
               sssx_pkg::ADDR_INSTR: s_axi_rdata_out <= {16'h0, instr_q};
               sssx_pkg::ADDR_OPA: s_axi_rdata_out <= opa_q;
               sssx_pkg::ADDR_OPB: s_axi_rdata_out <= opb_q;
               sssx_pkg::ADDR_SP: s_axi_rdata_out <= sp_q;
               sssx_pkg::ADDR_R0: s_axi_rdata_out <= r0_q;
               sssx_pkg::ADDR_RESULT: s_axi_rdata_out <= result_q;
               sssx_pkg::ADDR_FLAGS: s_axi_rdata_out <= {28'h0, flags_q};
               sssx_pkg::ADDR_MADDR: s_axi_rdata_out <= maddr_q;
               sssx_pkg::ADDR_MDATA: s_axi_rdata_out <= mdata_q;
               sssx_pkg::ADDR_STATUS: s_axi_rdata_out <= {26'h0, bad_q, pfx_valid_q, mstrb_q};
               default: begin
                  s_axi_rdata_out <= 32'h0;
                  s_axi_rresp_out <= sssx_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// File: sssx_mem_model.sv
// Purpose: data memory partner that records each store from the block
// Assumes: one store per pulse of the write strobe
// Notes: keeps only enabled lanes so misplaced bytes show up
`default_nettype none
module sssx_mem_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // store port
   input wire logic wr_in,
   input wire logic [31:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] be_in,
   // last store seen
   output logic [31:0] addr_out,
   output logic [31:0] data_out,
   output logic [3:0] be_out,
   output logic [31:0] count_out
);
   logic [31:0] lane_mask;
   always_comb begin
      for (int i = 0; i < 4; i++) lane_mask[i*8 +: 8] = {8{be_in[i]}};
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         addr_out <= 32'h0;
         data_out <= 32'h0;
         be_out <= 4'h0;
         count_out <= 32'h0;
      end else if (wr_in) begin
         addr_out <= addr_in;
         data_out <= wdata_in & lane_mask;
         be_out <= be_in;
         count_out <= count_out + 32'h1;
      end
   end
endmodule
`default_nettype wire

// File: sssx_top_properties.sv
// Purpose: port-level checks of store and bus timing
// Assumes: single clock domain
// Notes: attached by bind below
`default_nettype none
module sssx_top_checker (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // bus handshakes
   input wire logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic s_axi_arvalid_in,
   input wire logic s_axi_arready_out,
   input wire logic s_axi_rvalid_out,
   // data memory write
   input wire logic mem_wr_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic [3:0] mem_be_out
);
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_n_in);
   property p_aligned; mem_wr_out |-> mem_addr_out[1:0] == 2'h0; endproperty
   a_aligned: assert property (p_aligned)
      else $error("store address not word aligned");
   property p_lanes; mem_wr_out |-> mem_be_out inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
   endproperty
   a_lanes: assert property (p_lanes)
      else $error("illegal byte enable pattern");
   property p_byte_copy;
      mem_wr_out && $onehot(mem_be_out) |-> mem_wdata_out == {4{mem_wdata_out[7:0]}};
   endproperty
   a_byte_copy: assert property (p_byte_copy)
      else $error("byte store data not replicated");
   property p_half_copy;
      mem_wr_out && (mem_be_out == 4'h3 || mem_be_out == 4'hc)
         |-> mem_wdata_out[31:16] == mem_wdata_out[15:0];
   endproperty
   a_half_copy: assert property (p_half_copy)
      else $error("half store data not replicated");
   property p_pulse; mem_wr_out |=> !mem_wr_out; endproperty
   a_pulse: assert property (p_pulse)
      else $error("store strobe longer than one cycle");
   property p_after_commit; mem_wr_out |-> $past(s_axi_bvalid_out); endproperty
   a_after_commit: assert property (p_after_commit)
      else $error("store without a committed instruction");
   property p_addr_hold; !mem_wr_out |-> $stable(mem_addr_out); endproperty
   a_addr_hold: assert property (p_addr_hold)
      else $error("store address moved without a store");
   property p_read_answer; s_axi_arvalid_in && s_axi_arready_out |-> ##1 s_axi_rvalid_out; endproperty
   a_read_answer: assert property (p_read_answer)
      else $error("read answer late");
   property p_one_resp; s_axi_bvalid_out && s_axi_bready_in |=> !s_axi_bvalid_out; endproperty
   a_one_resp: assert property (p_one_resp)
      else $error("write response repeated");
endmodule
bind sssx_top sssx_top_checker sssx_top_checker_inst (.sys_clk_in, .rst_n_in, .s_axi_bvalid_out,
   .s_axi_bready_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rvalid_out, .mem_wr_out,
   .mem_addr_out, .mem_wdata_out, .mem_be_out);
`default_nettype wire

// File: sssx_top_tb.sv
// Purpose: self-checking bench for sssx_top
// Assumes: register map of sssx_pkg, stores captured by sssx_mem_model
// Notes: strobe check in reset, table rows, then prefix, refusal and reset cases
`default_nettype none
module sssx_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic [11:0] prefix_instruction;
      logic [15:0] ins;
      logic [31:0] a, b, sp;
      logic st;
      logic [31:0] ea, ed;
      logic [3:0] ebe;
      logic [31:0] eopa;
      logic [3:0] efl;
   } sssx_row_t;
   logic sys_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00;
   logic [7:0] s_axi_araddr_in = 8'h00;
   logic [31:0] s_axi_wdata_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hf;
   logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
   logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
   logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   logic s_axi_rvalid_out, mem_wr_out;
   logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rs;
   logic [31:0] s_axi_rdata_out, mem_addr_out, mem_wdata_out, rd, cnt0;
   logic [31:0] seen_addr, seen_data, seen_cnt;
   logic [3:0] mem_be_out, seen_be;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   sssx_row_t r;
   // ***************************
   // table: prefix, instr, a, b, sp, store, addr, data, lanes, first operand, flags
   // ***************************
   sssx_row_t rows [13] = '{
      '{12'h0,16'h0822,32'h5,32'h7,32'h0,1'b0,32'h0,32'h0,4'h0,32'hfffffffe,4'h9},
      '{12'h0,16'h7d03,32'h12345678,32'h0,32'h0,1'b0,32'h0,32'h0,4'h0,32'h56781234,4'h9},
      '{12'h0,16'h7664,32'hc,32'h0,32'h0,1'b1,32'hc,32'haa000000,4'h8,32'hc,4'h9},
      '{12'hfff,16'h7644,32'h100,32'h0,32'h0,1'b1,32'hfc,32'hbb0000,4'h4,32'h100,4'h9},
      '{12'h0,16'h0822,32'h80000000,32'h1,32'h0,1'b0,32'h0,32'h0,4'h0,32'h7fffffff,4'h4},
      '{12'h0,16'ha861,32'h5a5a1234,32'h0,32'h0,1'b1,32'h120c,32'h5a5a1234,4'hf,32'h5a5a1234,4'h4},
      '{12'hfff,16'ha3e1,32'h11,32'h0,32'h0,1'b1,32'hffc,32'h11,4'hf,32'h11,4'h4},
      '{12'h0,16'hdfe1,32'h22,32'h0,32'h2002,1'b1,32'h23fc,32'h22,4'hf,32'h22,4'h4},
      '{12'h0,16'h640e,32'h0,32'h0,32'h2000,1'b1,32'h200c,32'haabb0000,4'hc,32'h0,4'h4},
      '{12'h0,16'h600d,32'h0,32'h0,32'h2000,1'b1,32'h200c,32'hcc00,4'h2,32'h0,4'h4},
      '{12'hfff,16'h0c20,32'h10000,32'h0,32'h0,1'b0,32'h0,32'h0,4'h0,32'h1f,4'h0},
      '{12'h0,16'h0fe0,32'h1f,32'h0,32'h0,1'b0,32'h0,32'h0,4'h0,32'h0,4'h2},
      '{12'h0,16'hb861,32'h33,32'h0,32'h0,1'b0,32'h0,32'h0,4'h0,32'h33,4'h2}};
   sssx_top sssx_top_inst (.sys_clk_in, .rst_n_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
      .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
      .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in,
      .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
      .mem_wr_out, .mem_addr_out, .mem_wdata_out, .mem_be_out);
   sssx_mem_model sssx_mem_model_inst (.clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .wr_in(mem_wr_out), .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .be_in(mem_be_out),
      .addr_out(seen_addr), .data_out(seen_data), .be_out(seen_be), .count_out(seen_cnt));
   always #20 sys_clk_in = ~sys_clk_in;
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge sys_clk_in);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      while (aw || w) begin
         @(posedge sys_clk_in);
         if (aw && s_axi_awready_out) begin
            aw = 1'b0;
            s_axi_awvalid_in <= 1'b0;
         end
         if (w && s_axi_wready_out) begin
            w = 1'b0;
            s_axi_wvalid_in <= 1'b0;
         end
      end
      while (!s_axi_bvalid_out) @(posedge sys_clk_in);
      rs = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge sys_clk_in);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do @(posedge sys_clk_in); while (!s_axi_arready_out);
      s_axi_arvalid_in <= 1'b0;
      do @(posedge sys_clk_in); while (!s_axi_rvalid_out);
      rd = s_axi_rdata_out;
      rs = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
   endtask
   task automatic ex(input logic [15:0] ins);
      wr(sssx_pkg::ADDR_INSTR, {16'h0, ins});
      repeat (4) @(posedge sys_clk_in);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge sys_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         fails++;
         print_verdict();
      end
   end
   initial begin
      repeat (16) @(posedge sys_clk_in);
      check("strobe in reset", {28'h0, mem_be_out}, 32'h0);
      rst_n_in <= 1'b1;
      @(posedge sys_clk_in);
      wr(sssx_pkg::ADDR_R0, 32'haabbccdd);
      for (int k = 0; k < 4; k++) wr(sssx_pkg::ADDR_LOCAL + 8'(4 * k), 32'h1003 + 32'(k * 256));
      for (int i = 0; i < 13; i++) begin
         r = rows[i];
         cnt0 = seen_cnt;
         wr(sssx_pkg::ADDR_OPA, r.a);
         wr(sssx_pkg::ADDR_OPB, r.b);
         wr(sssx_pkg::ADDR_SP, r.sp);
         if (r.prefix_instruction[11]) ex({sssx_pkg::OP_PREFIX, r.prefix_instruction[10:0]});
         ex(r.ins);
         check("store count", seen_cnt, cnt0 + {31'h0, r.st});
         if (r.st) begin
            check("store address", seen_addr, r.ea);
            check("store data", seen_data, r.ed);
            check("store lanes", {28'h0, seen_be}, {28'h0, r.ebe});
         end
         rdr(sssx_pkg::ADDR_OPA);
         check("first operand", rd, r.eopa);
         rdr(sssx_pkg::ADDR_FLAGS);
         check("flags", {28'h0, rd[3:0]}, {28'h0, r.efl});
         $display("row %0d done", i);
      end
      ex({sssx_pkg::OP_PREFIX, 11'h7ff});
      rdr(sssx_pkg::ADDR_STATUS);
      check("prefix armed", {31'h0, rd[4]}, 32'h1);
      ex(16'h7d03);
      ex(16'ha861);
      check("prefix used once", seen_addr, 32'h120c);
      rdr(8'h2c);
      check("unmapped read", {rs, rd[29:0]}, {sssx_pkg::RESP_SLVERR, 30'h0});
      wr(8'h02, 32'h1);
      check("unaligned write", {30'h0, rs}, {30'h0, sssx_pkg::RESP_SLVERR});
      $display("refusal test done");
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge sys_clk_in);
      check("store strobe in reset", {31'h0, mem_wr_out}, 32'h0);
      rst_n_in <= 1'b1;
      @(posedge sys_clk_in);
      rdr(sssx_pkg::ADDR_FLAGS);
      check("flags after reset", {28'h0, rd[3:0]}, {28'h0, sssx_pkg::FLAGS_RST});
      $display("reset test done");
      print_verdict();
   end
endmodule
`default_nettype wire
